// ==== core/pcf_core.sv ====
/*
 Program pointer and condition-flag logic of an 8-bit CPU.
 Assumes memory read data arrive one cycle after a read strobe,
 writes complete in one cycle, and the decoder pulses op strobes.
*/
`timescale 1ns/100ps
module pcf_core (
   input wire logic clk_i,                      // Core clock
   input wire logic sys_rst_i,                  // Sync reset, high
   input wire logic fetch_i,                    // Byte fetched at pointer
   input wire logic flow_i,                     // Change of flow strobe
   input wire logic [15:0] flow_addr_i,         // Change of flow target
   input wire logic boundary_i,                 // Instruction boundary
   input wire logic irq_i,                      // Maskable request level
   input wire logic [15:0] irq_vec_addr_i,      // Vector address, high byte
   input wire logic [15:0] stack_ptr_i,         // Stack pointer for pushes
   input wire logic [7:0] index_low_i,          // Index low byte
   input wire logic [7:0] acc_i,                // Accumulator value
   input wire pcf_pkg::pcf_op_e op_i,           // ALU flag operation
   input wire logic [7:0] opa_i,                // Operand A
   input wire logic [7:0] opb_i,                // Operand B
   input wire logic wide_i,                     // Load/store is 16 bit
   input wire logic [15:0] ldst_val_i,          // Load/store value
   input wire logic shift_c_i,                  // Carry from shift/bit test
   input wire logic shift_v_i,                  // Overflow from shift
   input wire logic mask_clear_op_i,            // Clear interrupt mask
   input wire logic mask_set_op_i,              // Set interrupt mask
   input wire logic flags_wr_i,                 // Transfer into flags
   input wire logic [7:0] flags_wdata_i,        // Value to transfer
   input wire logic [7:0] mem_rdata_i,          // Memory read data
   output logic [15:0] next_fetch_pointer_o,    // Pointer value
   output logic [7:0] condition_flags_o,        // Flag register
   output logic [7:0] result_o,                 // ALU byte result
   output logic [15:0] mem_addr_o,              // Sequencer memory address
   output logic mem_rd_o,                       // Sequencer read strobe
   output logic mem_wr_o,                       // Sequencer write strobe
   output logic [7:0] mem_wdata_o,              // Stacked byte
   output logic busy_o,                         // Sequencer owns the bus
   output logic irq_taken_o                     // Interrupt accepted pulse
);
   import pcf_pkg::*;

   // Whole state of the block
   typedef struct packed {
      pcf_st_e st;
      logic [15:0] pc;
      logic [7:0] flg;
      logic [7:0] res;
      logic [2:0] cnt;
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
      logic inhibit;
      logic taken;
      logic [15:0] vec;
   } pcf_state_s;

   pcf_state_s cur_ff;
   pcf_state_s nxt_cur;

   // Next state logic
   always_comb begin
      logic [8:0] sum;
      logic [4:0] low;
      logic [7:0] adj;
      logic cin;
      logic sub;
      logic [7:0] b;
      logic [7:0] push_byte;
      nxt_cur = cur_ff;
      sum = 9'h000;
      low = 5'h00;
      adj = 8'h00;
      cin = 1'b0;
      sub = 1'b0;
      b = 8'h00;
      push_byte = 8'h00;
      nxt_cur.rd = 1'b0;
      nxt_cur.wr = 1'b0;
      nxt_cur.taken = 1'b0;
      unique case (cur_ff.st)
         // Fetch vector high byte after reset; cnt tracks strobe then data
         PCF_ST_VHI: begin
            nxt_cur.cnt = cur_ff.cnt + 3'h1;
            if (cur_ff.cnt == 3'h0) begin
               // Issue the first vector read
               nxt_cur.addr = VEC_HI_ADDR;
               nxt_cur.rd = 1'b1;
            end else if (cur_ff.cnt == 3'h2) begin
               // Data stand one cycle after the strobe, not with it
               nxt_cur.pc[15:8] = mem_rdata_i;
               // Low byte read goes out on the same edge
               nxt_cur.addr = VEC_LO_ADDR;
               nxt_cur.rd = 1'b1;
               nxt_cur.cnt = 3'h1;
               nxt_cur.st = PCF_ST_VLO;
            end
         end
         // Vector low byte, then run
         PCF_ST_VLO: begin
            nxt_cur.cnt = cur_ff.cnt + 3'h1;
            if (cur_ff.cnt == 3'h2) begin
               // Low byte arrives; pointer complete
               nxt_cur.pc[7:0] = mem_rdata_i;
               nxt_cur.cnt = 3'h0;
               nxt_cur.st = PCF_ST_RUN;
            end
         end
         // Normal execution
         PCF_ST_RUN: begin
            if (flow_i) begin
               nxt_cur.pc = flow_addr_i;
            end else if (fetch_i) begin
               nxt_cur.pc = cur_ff.pc + 16'h0001;
            end
            // Accept at boundary when unmasked and not inhibited
            if (boundary_i && irq_i && !cur_ff.flg[FLG_I]
                  && !cur_ff.inhibit) begin
               nxt_cur.st = PCF_ST_PUSH;
               nxt_cur.cnt = 3'h0;
               nxt_cur.vec = irq_vec_addr_i;
               nxt_cur.taken = 1'b1;
            end
            if (boundary_i) begin
               nxt_cur.inhibit = 1'b0;
            end
         end
         // Program pointer low and high bytes, index, acc, flags
         PCF_ST_PUSH: begin
            unique case (cur_ff.cnt)
               3'h0: push_byte = cur_ff.pc[7:0];
               3'h1: push_byte = cur_ff.pc[15:8];
               3'h2: push_byte = index_low_i;
               3'h3: push_byte = acc_i;
               default: push_byte = cur_ff.flg | FLG_ONES;
            endcase
            nxt_cur.wdata = push_byte;
            nxt_cur.addr = stack_ptr_i - {13'h0000, cur_ff.cnt};
            nxt_cur.wr = 1'b1;
            nxt_cur.cnt = cur_ff.cnt + 3'h1;
            if (cur_ff.cnt == PUSH_LAST) begin
               nxt_cur.flg[FLG_I] = 1'b1;
               // Vector fetch restarts its own count
               nxt_cur.cnt = 3'h0;
               nxt_cur.st = PCF_ST_IVHI;
            end
         end
         // Interrupt vector high byte, same strobe-then-data pattern
         PCF_ST_IVHI: begin
            nxt_cur.cnt = cur_ff.cnt + 3'h1;
            if (cur_ff.cnt == 3'h0) begin
               // Issue the vector read
               nxt_cur.addr = cur_ff.vec;
               nxt_cur.rd = 1'b1;
            end else if (cur_ff.cnt == 3'h2) begin
               // High byte taken the cycle after the strobe
               nxt_cur.pc[15:8] = mem_rdata_i;
               nxt_cur.addr = cur_ff.vec + 16'h0001;
               nxt_cur.rd = 1'b1;
               nxt_cur.cnt = 3'h1;
               nxt_cur.st = PCF_ST_IVLO;
            end
         end
         // Interrupt vector low byte
         PCF_ST_IVLO: begin
            nxt_cur.cnt = cur_ff.cnt + 3'h1;
            if (cur_ff.cnt == 3'h2) begin
               // Service routine start complete
               nxt_cur.pc[7:0] = mem_rdata_i;
               nxt_cur.cnt = 3'h0;
               nxt_cur.st = PCF_ST_RUN;
            end
         end
         default: begin
            // Illegal code: restart the vector fetch cleanly
            nxt_cur.st = PCF_ST_VHI;
            nxt_cur.cnt = 3'h0;
         end
      endcase

      // Flag updates; unlisted flags hold
      if (cur_ff.st == PCF_ST_RUN) begin
         sub = (op_i == PCF_OP_SUB) || (op_i == PCF_OP_SBC);
         cin = ((op_i == PCF_OP_ADC) || (op_i == PCF_OP_SBC)) && cur_ff.flg[FLG_C];
         b = sub ? ~opb_i : opb_i;
         unique case (op_i)
            // Add, add with carry
            PCF_OP_ADD, PCF_OP_ADC: begin
               sum = {1'b0, opa_i} + {1'b0, opb_i} + {8'h00, cin};
               low = {1'b0, opa_i[3:0]} + {1'b0, opb_i[3:0]} + {4'h0, cin};
               nxt_cur.flg[FLG_H] = low[4];
               nxt_cur.flg[FLG_C] = sum[8];
               nxt_cur.flg[FLG_V] = (opa_i[7] == opb_i[7]) && (sum[7] != opa_i[7]);
               nxt_cur.res = sum[7:0];
               nxt_cur.flg[FLG_N] = sum[7];
               nxt_cur.flg[FLG_Z] = (sum[7:0] == 8'h00);
            end
            // Subtract, subtract with borrow
            PCF_OP_SUB, PCF_OP_SBC: begin
               sum = {1'b0, opa_i} + {1'b0, b} + {8'h00, ~cin};
               nxt_cur.flg[FLG_C] = ~sum[8];
               nxt_cur.flg[FLG_V] = (opa_i[7] != opb_i[7]) && (sum[7] != opa_i[7]);
               nxt_cur.res = sum[7:0];
               nxt_cur.flg[FLG_N] = sum[7];
               nxt_cur.flg[FLG_Z] = (sum[7:0] == 8'h00);
            end
            // Logic result in operand A; overflow cleared
            PCF_OP_LOGIC: begin
               nxt_cur.res = opa_i;
               nxt_cur.flg[FLG_V] = 1'b0;
               nxt_cur.flg[FLG_N] = opa_i[7];
               nxt_cur.flg[FLG_Z] = (opa_i == 8'h00);
            end
            // Plain load or store
            PCF_OP_LDST: begin
               nxt_cur.res = ldst_val_i[7:0];
               nxt_cur.flg[FLG_V] = 1'b0;
               nxt_cur.flg[FLG_N] = wide_i ? ldst_val_i[15] : ldst_val_i[7];
               nxt_cur.flg[FLG_Z] = wide_i ? (ldst_val_i == 16'h0000)
                                           : (ldst_val_i[7:0] == 8'h00);
            end
            // Shift or rotate result in operand A
            PCF_OP_SHIFT: begin
               nxt_cur.res = opa_i;
               nxt_cur.flg[FLG_C] = shift_c_i;
               nxt_cur.flg[FLG_V] = shift_v_i;
               nxt_cur.flg[FLG_N] = opa_i[7];
               nxt_cur.flg[FLG_Z] = (opa_i == 8'h00);
            end
            // Bit test and branch: only carry
            PCF_OP_BTST: begin
               nxt_cur.flg[FLG_C] = shift_c_i;
            end
            // Decimal adjust of previous sum in operand A
            PCF_OP_DAA: begin
               if (cur_ff.flg[FLG_H] || (opa_i[3:0] > 4'h9)) begin
                  adj[3:0] = 4'h6;
               end
               if (cur_ff.flg[FLG_C] || (opa_i > 8'h99)) begin
                  adj[7:4] = 4'h6;
               end
               sum = {1'b0, opa_i} + {1'b0, adj};
               nxt_cur.res = sum[7:0];
               nxt_cur.flg[FLG_C] = cur_ff.flg[FLG_C] | sum[8] | adj[6];
               nxt_cur.flg[FLG_N] = sum[7];
               nxt_cur.flg[FLG_Z] = (sum[7:0] == 8'h00);
            end
            default: begin
               nxt_cur.res = cur_ff.res;
            end
         endcase
         // Direct transfer into flags
         if (flags_wr_i) begin
            nxt_cur.flg = flags_wdata_i;
            if (cur_ff.flg[FLG_I] && !flags_wdata_i[FLG_I]) begin
               nxt_cur.inhibit = 1'b1;
            end
         end
         // Mask set and clear operations
         if (mask_set_op_i) begin
            nxt_cur.flg[FLG_I] = 1'b1;
         end else if (mask_clear_op_i) begin
            nxt_cur.flg[FLG_I] = 1'b0;
            if (cur_ff.flg[FLG_I]) begin
               nxt_cur.inhibit = 1'b1;
            end
         end
      end
      nxt_cur.flg = nxt_cur.flg | FLG_ONES;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cur_ff <= '{st: PCF_ST_VHI, pc: 16'h0000, flg: FLG_RST, res: 8'h00,
                     cnt: 3'h0, addr: 16'h0000, rd: 1'b0, wr: 1'b0,
                     wdata: 8'h00, inhibit: 1'b0, taken: 1'b0, vec: 16'h0000};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs from state
   assign next_fetch_pointer_o = cur_ff.pc;
   assign condition_flags_o = cur_ff.flg | FLG_ONES;
   assign result_o = cur_ff.res;
   assign mem_addr_o = cur_ff.addr;
   assign mem_rd_o = cur_ff.rd;
   assign mem_wr_o = cur_ff.wr;
   assign mem_wdata_o = cur_ff.wdata;
   assign busy_o = (cur_ff.st != PCF_ST_RUN);
   assign irq_taken_o = cur_ff.taken;
endmodule // pcf_core

// ==== core/pcf_pkg.sv ====
/*
 Constants for the program-pointer and condition-flag block.
 Assumes a decoder that supplies one-cycle operation strobes on one clock.
*/
// Contract
// - Hold 16-bit pointer to next fetch byte
// - Pointer advances by one per fetch
// - Change of flow loads non-sequential target
// - Reset loads pointer from vector FFFE/FFFF
// - Flags 8 bits, bits 6,5 read 1
// - Bit 7 overflow on two's complement overflow
// - Bit 4 half-carry from add bit 3
// - Decimal adjust uses half-carry and carry
// - Mask bit 3 set blocks maskable interrupts
// - Mask set after stacking, before service code
// - No interrupt at boundary after mask clear
// - Bit 2 negative when result bit 7 set
// - Load/store sets negative from value MSB
// - Bit 1 zero when result is zero
// - Load/store sets zero when value zero
// - Bit 0 carry on add carry or borrow
// - Bit-test, shift, rotate also set carry
// - Entry stacks low, high, index, acc, flags
package pcf_pkg;
   // Reset vector addresses
   localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
   localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
   // Flag bit positions
   localparam int FLG_V = 7;
   localparam int FLG_H = 4;
   localparam int FLG_I = 3;
   localparam int FLG_N = 2;
   localparam int FLG_Z = 1;
   localparam int FLG_C = 0;
   // Bits that always read 1
   localparam logic [7:0] FLG_ONES = 8'h60;
   // Flags at reset: mask set
   localparam logic [7:0] FLG_RST = 8'h68;
   // ALU operation codes
   typedef enum logic [3:0] {
      PCF_OP_NONE = 4'h0,
      PCF_OP_ADD  = 4'h1,
      PCF_OP_ADC  = 4'h2,
      PCF_OP_SUB  = 4'h3,
      PCF_OP_SBC  = 4'h4,
      PCF_OP_LOGIC = 4'h5,
      PCF_OP_LDST = 4'h6,
      PCF_OP_SHIFT = 4'h7,
      PCF_OP_DAA  = 4'h8,
      PCF_OP_BTST = 4'h9
   } pcf_op_e;
   // Sequencer states
   typedef enum logic [3:0] {
      PCF_ST_VHI  = 4'h0,
      PCF_ST_VLO  = 4'h1,
      PCF_ST_RUN  = 4'h2,
      PCF_ST_PUSH = 4'h3,
      PCF_ST_IVHI = 4'h4,
      PCF_ST_IVLO = 4'h5
   } pcf_st_e;
   // Count value of the last of the five bytes stacked on interrupt entry
   localparam logic [2:0] PUSH_LAST = 3'h4;
endpackage

// ==== dv/pcf_sva.sv ====
/* Port assertions for pcf_core.
   Bound to every pcf_core; one clock, sync reset. */
`timescale 1ns/100ps
module pcf_sva (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic fetch_i,
   input wire logic flow_i,
   input wire logic [15:0] flow_addr_i,
   input wire logic boundary_i,
   input wire logic irq_i,
   input wire pcf_pkg::pcf_op_e op_i,
   input wire logic [7:0] opa_i,
   input wire logic [7:0] opb_i,
   input wire logic wide_i,
   input wire logic [15:0] ldst_val_i,
   input wire logic [15:0] next_fetch_pointer_o,
   input wire logic [7:0] condition_flags_o,
   input wire logic [7:0] result_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic mem_rd_o,
   input wire logic mem_wr_o,
   input wire logic [7:0] mem_wdata_o,
   input wire logic busy_o,
   input wire logic irq_taken_o
);
   import pcf_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic run; // Ops taken
   logic [8:0] s; // Sum with carry
   logic [7:0] f; // Flags
   logic [15:0] p; // Pointer
   assign run = !busy_o;
   assign s = {1'b0, opa_i} + {1'b0, opb_i};
   assign f = condition_flags_o;
   assign p = next_fetch_pointer_o;
   ones_fixed_a: assert property (f[6:5] == 2'b11)
      else $error("fixed bits");
   ptr_step_a: assert property (run && fetch_i && !flow_i |=> p == $past(p) + 16'h0001)
      else $error("no step");
   flow_load_a: assert property (run && flow_i |=> p == $past(flow_addr_i))
      else $error("no flow");
   vec_read_a: assert property ($fell(sys_rst_i) |-> ##[0:3] (mem_rd_o && mem_addr_o == VEC_HI_ADDR))
      else $error("no vector");
   add_flags_a: assert property (run && op_i == PCF_OP_ADD |=> f[0] == $past(s[8])
      && f[4] == $past(opa_i[4] ^ opb_i[4] ^ s[4]) && result_o == $past(s[7:0])
      && f[7] == $past(opa_i[7] == opb_i[7] && s[7] != opa_i[7])) else $error("add flags");
   logic_nz_a: assert property (run && op_i == PCF_OP_LOGIC |=>
      f[2:1] == $past({opa_i[7], opa_i == 8'h00})) else $error("logic flags");
   ldst_nz_a: assert property (run && op_i == PCF_OP_LDST |=> f[2:1] == $past(wide_i ?
      {ldst_val_i[15], ldst_val_i == 16'h0000} : {ldst_val_i[7], ldst_val_i[7:0] == 8'h00}))
      else $error("move flags");
   irq_mask_a: assert property (run && boundary_i && irq_i && f[3] |=> !irq_taken_o)
      else $error("masked taken");
   entry_seq_a: assert property (irq_taken_o |=> mem_wr_o [*4] ##1 (mem_wr_o && !mem_wdata_o[3])
      ##[0:2] f[3]) else $error("entry order");
endmodule // pcf_sva
bind pcf_core pcf_sva u_pcf_sva (.*);

// ==== dv/pcf_mem.sv ====
/* Memory partner: answers a read in the next cycle only.
   Vector bytes preset from parameters; values arbitrary. */
`timescale 1ns/100ps
module pcf_mem #(
   parameter logic [15:0] RST_VEC = 16'h1234, // Arbitrary start
   parameter logic [15:0] IRQ_VEC = 16'hFFF0, // Vector place
   parameter logic [15:0] ISR_VEC = 16'h4321 // Arbitrary service start
) (
   input wire logic clk_i, // Core clock
   input wire logic [15:0] mem_addr_i, // Address
   input wire logic mem_rd_i, // Read strobe
   input wire logic mem_wr_i, // Write strobe
   input wire logic [7:0] mem_wdata_i, // Write data
   output logic [7:0] mem_rdata_o // Read data
);
   logic [7:0] mem [0:65535]; // Byte store
   // Vectors, high byte first
   initial begin
      mem[16'hFFFE] = RST_VEC[15:8];
      mem[16'hFFFF] = RST_VEC[7:0];
      mem[IRQ_VEC] = ISR_VEC[15:8];
      mem[IRQ_VEC + 16'h0001] = ISR_VEC[7:0];
      mem_rdata_o = 8'h00;
   end
   // Stale data inverted so nobody leans on it
   always @(posedge clk_i) begin
      if (mem_wr_i) begin
         mem[mem_addr_i] <= mem_wdata_i;
      end
      mem_rdata_o <= mem_rd_i ? mem[mem_addr_i] : ~mem_rdata_o;
   end
endmodule // pcf_mem

// ==== dv/tb.sv ====
/* Self-checking bench for pcf_core with a memory partner.
   Assumes pcf_sva is bound from its own file. */
`timescale 1ns/100ps
module tb;
   import pcf_pkg::*;
   localparam logic [15:0] RV = 16'h1234; // Start, arbitrary
   localparam logic [15:0] IV = 16'h4321; // Service, arbitrary
   logic clk_i = 1'b0, sys_rst_i = 1'b1, fetch_i = 1'b0, flow_i = 1'b0, boundary_i = 1'b0;
   logic irq_i = 1'b0, wide_i = 1'b0, shift_c_i = 1'b0, shift_v_i = 1'b0, flags_wr_i = 1'b0;
   logic mask_clear_op_i = 1'b0, mask_set_op_i = 1'b0, mem_rd_o, mem_wr_o, busy_o, irq_taken_o;
   logic [15:0] flow_addr_i = '0, stack_ptr_i = '0, ldst_val_i = '0, irq_vec_addr_i = 16'hFFF0;
   logic [15:0] next_fetch_pointer_o, mem_addr_o, ep;
   logic [7:0] index_low_i = '0, acc_i = '0, opa_i = '0, opb_i = '0, flags_wdata_i = '0;
   logic [7:0] condition_flags_o, result_o, mem_rdata_i, mem_wdata_o, ef, kn;
   logic [7:0] pb [5]; // Expected stacked bytes
   pcf_op_e op_i = PCF_OP_NONE, o;
   int err_total = 0, checks_done = 0, taken = 0, n;
   pcf_core u_pcf_core (.*);
   pcf_mem #(.RST_VEC(RV), .ISR_VEC(IV)) u_pcf_mem (.clk_i, .mem_addr_i(mem_addr_o),
      .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // Count accepted interrupts
   always @(posedge clk_i) begin
      if (irq_taken_o === 1'b1) taken++;
   end
   task automatic tick;
      @(posedge clk_i);
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
      checks_done++;
      if ((g & m) !== (e & m)) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
      chk({8'h00, g}, {8'h00, e}, {8'h00, m});
   endtask
   task automatic wrap_up;
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Wait out vector fetch or entry
   task automatic idle;
      repeat (2) @(posedge clk_i);
      for (n = 0; n < 60 && busy_o !== 1'b0; n++) @(posedge clk_i);
      #1;
      chk8({7'h00, busy_o}, 8'h00, 8'hFF);
   endtask
   // Expected {result, flags}
   function automatic logic [15:0] calc(pcf_op_e x, logic [7:0] a, logic [7:0] b, logic [7:0] f);
      logic [8:0] s;
      logic c;
      c = f[0] & (x == PCF_OP_ADC || x == PCF_OP_SBC);
      s = {1'b0, a};
      case (x)
         PCF_OP_ADD, PCF_OP_ADC: begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, c};
            f[4] = a[4] ^ b[4] ^ s[4];
            f[7] = (a[7] == b[7]) && (s[7] != a[7]);
         end
         PCF_OP_SUB, PCF_OP_SBC: begin
            s = {1'b0, a} - {1'b0, b} - {8'h00, c};
            f[7] = (a[7] != b[7]) && (s[7] != a[7]);
         end
         PCF_OP_LOGIC: f[7] = 1'b0;
         PCF_OP_LDST: f[7] = 1'b0;
         PCF_OP_SHIFT: f[7] = shift_v_i;
         default: ;
      endcase
      if (x inside {[PCF_OP_ADD:PCF_OP_SBC]}) f[0] = s[8];
      if (x inside {PCF_OP_SHIFT, PCF_OP_BTST}) f[0] = shift_c_i;
      if (x inside {[PCF_OP_ADD:PCF_OP_LOGIC], PCF_OP_SHIFT}) f[2:1] = {s[7], s[7:0] == 8'h00};
      if (x == PCF_OP_LDST) f[2:1] = wide_i ? {ldst_val_i[15], ldst_val_i == 16'h0000}
         : {ldst_val_i[7], ldst_val_i[7:0] == 8'h00};
      return {s[7:0], f};
   endfunction
   task automatic alu(input pcf_op_e x, input logic [7:0] a, input logic [7:0] b);
      logic [15:0] r;
      tick;
      op_i <= x;
      opa_i <= a;
      opb_i <= b;
      wide_i <= 1'($urandom);
      shift_c_i <= 1'($urandom);
      shift_v_i <= 1'($urandom);
      ldst_val_i <= 16'($urandom);
      tick;
      op_i <= PCF_OP_NONE;
      tick;
      #1;
      r = calc(x, a, b, ef);
      ef = r[7:0];
      if (x inside {[PCF_OP_ADD:PCF_OP_LOGIC], PCF_OP_SHIFT}) begin
         kn[7] = 1'b1;
         chk8(result_o, r[15:8], 8'hFF);
      end
      if (x != PCF_OP_DAA) chk8(condition_flags_o, ef, kn);
   endtask
   task automatic setf(input logic [7:0] v);
      tick;
      flags_wr_i <= 1'b1;
      flags_wdata_i <= v;
      tick;
      flags_wr_i <= 1'b0;
      tick;
      #1;
      ef = v | FLG_ONES;
      kn = 8'hFF;
      chk8(condition_flags_o, ef, kn);
   endtask
   initial begin
      void'($urandom(74));
      repeat (10) tick;
      sys_rst_i <= 1'b0;
      idle;
      chk(next_fetch_pointer_o, RV, 16'hFFFF);
      chk8(condition_flags_o, FLG_RST, 8'hFF);
      n = $urandom_range(20, 3);
      tick;
      fetch_i <= 1'b1;
      repeat (n) tick;
      fetch_i <= 1'b0;
      tick;
      #1;
      chk(next_fetch_pointer_o, RV + 16'(n), 16'hFFFF);
      ep = 16'($urandom);
      tick;
      flow_addr_i <= ep;
      flow_i <= 1'b1;
      fetch_i <= 1'b1;
      tick;
      flow_i <= 1'b0;
      fetch_i <= 1'b0;
      tick;
      #1;
      chk(next_fetch_pointer_o, ep, 16'hFFFF);
      setf(8'($urandom));
      repeat (300) begin
         o = pcf_op_e'(4'($urandom_range(9, 0)));
         alu((o == PCF_OP_DAA) ? PCF_OP_NONE : o, 8'($urandom), 8'($urandom));
      end
      alu(PCF_OP_ADD, 8'h09, 8'h08);
      alu(PCF_OP_DAA, 8'h11, 8'h00);
      chk8(result_o, 8'h17, 8'hFF);
      alu(PCF_OP_ADD, 8'h99, 8'h01);
      alu(PCF_OP_DAA, 8'h9A, 8'h00);
      chk8({result_o[7:1], condition_flags_o[0]}, 8'h01, 8'hFF);
      // Mask set and clear together from a clear mask: set wins
      setf(8'h00);
      tick;
      mask_set_op_i <= 1'b1;
      mask_clear_op_i <= 1'b1;
      tick;
      mask_set_op_i <= 1'b0;
      mask_clear_op_i <= 1'b0;
      tick;
      #1;
      chk8(condition_flags_o, 8'h08, 8'h08);
      setf(8'($urandom) | 8'h08);
      tick;
      stack_ptr_i <= {8'h02, 8'($urandom)};
      index_low_i <= 8'($urandom);
      acc_i <= 8'($urandom);
      irq_i <= 1'b1;
      boundary_i <= 1'b1;
      tick;
      boundary_i <= 1'b0;
      repeat (3) tick;
      chk8(8'(taken), 8'h00, 8'hFF);
      mask_clear_op_i <= 1'b1;
      tick;
      mask_clear_op_i <= 1'b0;
      boundary_i <= 1'b1;
      tick;
      boundary_i <= 1'b0;
      repeat (3) tick;
      chk8(8'(taken), 8'h00, 8'hFF);
      boundary_i <= 1'b1;
      tick;
      boundary_i <= 1'b0;
      irq_i <= 1'b0;
      idle;
      chk8(8'(taken), 8'h01, 8'hFF);
      chk(next_fetch_pointer_o, IV, 16'hFFFF);
      chk8(condition_flags_o, 8'h08, 8'h08);
      pb = '{ep[7:0], ep[15:8], index_low_i, acc_i, ef & 8'hF7};
      for (int k = 0; k < 5; k++) chk8(u_pcf_mem.mem[stack_ptr_i - 16'(k)], pb[k], 8'hFF);
      // Second reset in mid-run: vector fetch again
      tick;
      sys_rst_i <= 1'b1;
      repeat (2) tick;
      sys_rst_i <= 1'b0;
      idle;
      chk(next_fetch_pointer_o, RV, 16'hFFFF);
      chk8(condition_flags_o, FLG_RST, 8'hFF);
      wrap_up;
   end
   // Hang guard, well past the expected run
   initial begin
      repeat (8000) @(posedge clk_i);
      err_total++;
      wrap_up;
   end
endmodule // tb
